// ===== src/sdram_core_pkg.sv
// constants, types and helper functions for the two-bank sdram command core
`default_nettype none
package sdram_core_pkg;

  // geometry
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DQ_W = 16;
  localparam int MEM_AW = 1 + ROW_W + COL_W;
  localparam int BANK_SELECT_BIT = 11;
  localparam int PRECHARGE_SCOPE_BIT = 10;
  localparam logic [8:0] FULL_PAGE_LEN = 9'h100;

  // timing, figures in ns and derived cycle counts (least times round up)
  localparam int CLK_NS = 4;
  localparam int TRAS_NS = 42;
  localparam int TRP_NS = 20;
  localparam logic [7:0] TRAS_CYC = 8'((TRAS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] TRP_CYC = 8'((TRP_NS + CLK_NS - 1) / CLK_NS);

  // apb register map
  localparam logic [11:0] CFG_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] ERR_OFF = 12'h008;
  localparam logic [11:0] ROW_OFF = 12'h00C;
  localparam int CFG_LAT3_BIT = 0;
  localparam int CFG_BL_LSB = 1;
  localparam int CFG_IL_BIT = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam int ERR_EARLY_PRE = 0;
  localparam int ERR_CLOSED_BANK = 1;
  localparam int ERR_ACT_BUSY = 2;

  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_BST, CMD_REF, CMD_MRS} cmd_e;

  // command pins sampled on the rising edge
  typedef struct packed {
    logic chip_sel_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_en_n;
    logic [11:0] addr;
    logic upper_byte_mask;
    logic lower_byte_mask;
  } sdram_pins_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  function automatic cmd_e decode_cmd(input sdram_pins_s p);
    cmd_e c;
    c = CMD_NOP;
    if (!p.chip_sel_n)
    begin
      case ({p.row_strobe_n, p.col_strobe_n, p.write_en_n})
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRE;
        3'h6: c = CMD_BST;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // reserved length codes behave as a single-word burst
  function automatic logic [8:0] burst_len(input logic [2:0] code);
    case (code)
      3'h1: return 9'h002;
      3'h2: return 9'h004;
      3'h3: return 9'h008;
      BL_FULL: return FULL_PAGE_LEN;
      default: return 9'h001;
    endcase
  endfunction

  // column of a given beat; upper bits stay fixed, low bits wrap in the burst
  function automatic logic [7:0] burst_col(input logic [7:0] start, input logic [7:0] beat,
                                           input logic [2:0] code, input logic il);
    logic [7:0] m;
    logic [7:0] seq;
    m = 8'((burst_len(code) - 9'h001));
    seq = start + beat;
    if (il && code != BL_FULL)
      return (start & ~m) | ((start ^ beat) & m);
    return (start & ~m) | (seq & m);
  endfunction

endpackage
`default_nettype wire

// ===== src/sdram_cell_array.sv
// storage array with byte writes and a registered read port
`default_nettype none
module sdram_cell_array #(
  parameter int AW = 20,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic [1:0] be,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_r
);

  logic [DW-1:0] cells [0:(1 << AW)-1];

  // byte-lane writes; read data leaves through a register
  always_ff @(posedge clk)
  begin
    if (we && be[0])
      cells[addr][DW/2-1:0] <= wdata[DW/2-1:0];
    if (we && be[1])
      cells[addr][DW-1:DW/2] <= wdata[DW-1:DW/2];
    rdata_r <= cells[addr];
  end

endmodule
`default_nettype wire

// ===== src/sdram_burst_bank_command_core.sv
// two-bank sdram command decode, burst engine, data pipeline and apb registers
`default_nettype none
module sdram_burst_bank_command_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdram_core_pkg::apb_req_s apb_req,
  output sdram_core_pkg::apb_rsp_s apb_rsp,
  input wire sdram_core_pkg::sdram_pins_s sd_pins,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic [1:0] dq_oe
);

  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_e;

  typedef struct packed {
    // per-bank state
    logic [1:0] bank_open;
    logic [1:0][10:0] bank_row;
    logic [1:0][7:0] ras_cnt;
    logic [1:0][7:0] rp_cnt;
    // burst engine
    eng_e eng;
    logic eng_bank;
    logic [7:0] eng_start;
    logic [7:0] eng_beat;
    logic eng_ap;
    logic ap_pend;
    logic ap_bank;
    // read data pipeline
    logic rv1;
    logic rv2;
    logic [15:0] rdat2;
    logic [1:0] mask_q;
    logic [15:0] dq_out;
    logic [1:0] dq_oe;
    // software visible
    logic [4:0] cfg;
    logic [2:0] err;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic [19:0] mem_addr;
  logic mem_we;
  logic [1:0] mem_be;
  logic [15:0] mem_rdata;

  sdram_cell_array #(
    .AW(sdram_core_pkg::MEM_AW),
    .DW(sdram_core_pkg::DQ_W)
  ) u_cells (
    .clk(pclk),
    .addr(mem_addr),
    .we(mem_we),
    .be(mem_be),
    .wdata(dq_in),
    .rdata_r(mem_rdata)
  );

  // the whole block is one next-state process
  always_comb
  begin
    sdram_core_pkg::cmd_e cmd;
    logic cmd_bank;
    logic [2:0] bl_code;
    logic [8:0] bl;
    logic full;
    logic lat3;
    logic issue_rd;
    logic [7:0] col;
    logic use_bank;
    logic stop_now;
    logic [11:0] addr;
    logic rd_v;
    cmd = sdram_core_pkg::decode_cmd(sd_pins);
    s_nxt = s_r;
    addr = sd_pins.addr;
    bl_code = s_r.cfg[sdram_core_pkg::CFG_BL_LSB +: 3];
    bl = sdram_core_pkg::burst_len(bl_code);
    full = (bl_code == sdram_core_pkg::BL_FULL);
    lat3 = s_r.cfg[sdram_core_pkg::CFG_LAT3_BIT];
    cmd_bank = addr[sdram_core_pkg::BANK_SELECT_BIT];
    issue_rd = 1'b0;
    mem_we = 1'b0;
    mem_be = ~{sd_pins.upper_byte_mask, sd_pins.lower_byte_mask};
    col = 8'h00;
    use_bank = s_r.eng_bank;
    stop_now = 1'b0;
    rd_v = 1'b0;

    // apb slave: answer from a register one cycle after setup
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (apb_req.psel && !apb_req.penable)
    begin
      s_nxt.pready = 1'b1;
      case (apb_req.paddr)
        sdram_core_pkg::CFG_OFF: s_nxt.prdata = {27'h0000000, s_r.cfg};
        sdram_core_pkg::STAT_OFF:
          s_nxt.prdata = {24'h000000, s_r.eng == ENG_WRITE, s_r.eng == ENG_READ, s_r.ap_pend,
                          1'b0, s_r.rp_cnt[1] != 8'h00, s_r.rp_cnt[0] != 8'h00, s_r.bank_open};
        sdram_core_pkg::ERR_OFF: s_nxt.prdata = {29'h00000000, s_r.err};
        sdram_core_pkg::ROW_OFF: s_nxt.prdata = {5'h00, s_r.bank_row[1], 5'h00, s_r.bank_row[0]};
        default:
        begin
          s_nxt.prdata = 32'h00000000;
          s_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // writes land on the access edge; error bits are write-one-to-clear
    if (apb_req.psel && apb_req.penable && s_r.pready && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        sdram_core_pkg::CFG_OFF: s_nxt.cfg = apb_req.pwdata[4:0];
        sdram_core_pkg::ERR_OFF: s_nxt.err = s_r.err & ~apb_req.pwdata[2:0];
        default: s_nxt.cfg = s_r.cfg;
      endcase
    end

    // activate-to-precharge and precharge-period timers
    for (int b = 0; b < 2; b++)
    begin
      if (s_r.ras_cnt[b] != 8'h00)
        s_nxt.ras_cnt[b] = s_r.ras_cnt[b] - 8'h01;
      if (s_r.rp_cnt[b] != 8'h00)
        s_nxt.rp_cnt[b] = s_r.rp_cnt[b] - 8'h01;
    end

    // auto-precharge starts one edge after the last issued word; for reads
    // this lands latency-1 edges before the last output word
    if (s_r.ap_pend)
    begin
      s_nxt.bank_open[s_r.ap_bank] = 1'b0;
      s_nxt.rp_cnt[s_r.ap_bank] = sdram_core_pkg::TRP_CYC;
      s_nxt.ap_pend = 1'b0;
    end

    // continue a running burst at the next generated column
    if (s_r.eng != ENG_IDLE)
    begin
      col = sdram_core_pkg::burst_col(s_r.eng_start, s_r.eng_beat, bl_code, s_r.cfg[sdram_core_pkg::CFG_IL_BIT]);
      s_nxt.eng_beat = s_r.eng_beat + 8'h01;
      if (!full && ({1'b0, s_r.eng_beat} + 9'h001 == bl))
      begin
        s_nxt.eng = ENG_IDLE;
        if (s_r.eng_ap)
        begin
          s_nxt.ap_pend = 1'b1;
          s_nxt.ap_bank = s_r.eng_bank;
        end
      end
    end

    case (cmd)
      sdram_core_pkg::CMD_ACT:
      begin
        if (s_r.bank_open[cmd_bank] || s_r.rp_cnt[cmd_bank] != 8'h00)
          s_nxt.err[sdram_core_pkg::ERR_ACT_BUSY] = 1'b1;
        s_nxt.bank_open[cmd_bank] = 1'b1;
        s_nxt.bank_row[cmd_bank] = addr[10:0];
        s_nxt.ras_cnt[cmd_bank] = sdram_core_pkg::TRAS_CYC;
      end
      sdram_core_pkg::CMD_PRE:
      begin
        for (int b = 0; b < 2; b++)
        begin
          // scope bit high covers both banks and ignores the bank bit
          if (addr[sdram_core_pkg::PRECHARGE_SCOPE_BIT] || cmd_bank == 1'(b))
          begin
            if (s_r.bank_open[b])
            begin
              if (s_r.ras_cnt[b] != 8'h00)
                s_nxt.err[sdram_core_pkg::ERR_EARLY_PRE] = 1'b1;
              s_nxt.bank_open[b] = 1'b0;
              s_nxt.rp_cnt[b] = sdram_core_pkg::TRP_CYC;
            end
            if (s_r.eng != ENG_IDLE && s_r.eng_bank == 1'(b))
              stop_now = 1'b1;
          end
        end
      end
      sdram_core_pkg::CMD_BST:
        stop_now = (s_r.eng != ENG_IDLE);
      sdram_core_pkg::CMD_READ, sdram_core_pkg::CMD_WRITE:
      begin
        // a new column command replaces whatever burst was running
        if (!s_r.bank_open[cmd_bank])
          s_nxt.err[sdram_core_pkg::ERR_CLOSED_BANK] = 1'b1;
        use_bank = cmd_bank;
        col = addr[7:0];
        s_nxt.eng_bank = cmd_bank;
        s_nxt.eng_start = addr[7:0];
        s_nxt.eng_beat = 8'h01;
        s_nxt.eng_ap = addr[sdram_core_pkg::PRECHARGE_SCOPE_BIT] && !full;
        if (bl == 9'h001)
        begin
          s_nxt.eng = ENG_IDLE;
          if (s_nxt.eng_ap)
          begin
            s_nxt.ap_pend = 1'b1;
            s_nxt.ap_bank = cmd_bank;
          end
        end
        else if (cmd == sdram_core_pkg::CMD_READ)
          s_nxt.eng = ENG_READ;
        else
          s_nxt.eng = ENG_WRITE;
      end
      default:
        stop_now = 1'b0;
    endcase

    // stopped bursts issue nothing on the stop edge
    if (stop_now)
      s_nxt.eng = ENG_IDLE;

    // drive the array for this edge
    if (cmd == sdram_core_pkg::CMD_READ)
      issue_rd = 1'b1;
    else if (cmd == sdram_core_pkg::CMD_WRITE)
      mem_we = 1'b1;
    else if (!stop_now && s_r.eng == ENG_READ)
      issue_rd = 1'b1;
    else if (!stop_now && s_r.eng == ENG_WRITE)
      mem_we = 1'b1;
    mem_addr = {use_bank, s_r.bank_row[use_bank], col};

    // read pipeline: array register is stage one, latency 3 adds stage two
    s_nxt.rv1 = issue_rd;
    s_nxt.rv2 = s_r.rv1;
    s_nxt.rdat2 = mem_rdata;
    rd_v = lat3 ? s_r.rv2 : s_r.rv1;
    s_nxt.dq_out = lat3 ? s_r.rdat2 : mem_rdata;
    // drivers follow read valid, so they rise latency-1 edges after the
    // read and fall by themselves after the last word or a stop
    s_nxt.dq_oe = {2{rd_v}} & ~s_r.mask_q;
    // mask sampled here gates the output register one edge later: two in all
    s_nxt.mask_q = {sd_pins.upper_byte_mask, sd_pins.lower_byte_mask};
  end

  // single state register; asynchronous reset to constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.cfg <= sdram_core_pkg::CFG_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // every output comes straight from the state register
  assign apb_rsp = '{prdata: s_r.prdata, pready: s_r.pready, pslverr: s_r.pslverr};
  assign dq_out = s_r.dq_out;
  assign dq_oe = s_r.dq_oe;

endmodule
`default_nettype wire

// ===== bench/sdram_core_checker.sv
// concurrent checks on the apb port and sdram pins of the command core
`default_nettype none
module sdram_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire sdram_core_pkg::apb_req_s apb_req,
  input wire sdram_core_pkg::apb_rsp_s apb_rsp,
  input wire sdram_core_pkg::sdram_pins_s sd_pins,
  input wire logic [15:0] dq_out,
  input wire logic [1:0] dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lat3_r;
  logic [2:0] bl_r;
  logic rd;
  logic unmasked;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of latency and length, taken only at the access edge like the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lat3_r <= 1'h0;
      bl_r <= 3'h0;
    end
    else if (apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == 12'h000)
    begin
      lat3_r <= apb_req.pwdata[0];
      bl_r <= apb_req.pwdata[3:1];
    end
  end
  // read decoded from the raw pins, not from the package helper
  assign rd = !sd_pins.chip_sel_n && sd_pins.row_strobe_n && !sd_pins.col_strobe_n && sd_pins.write_en_n;
  assign unmasked = !sd_pins.upper_byte_mask && !sd_pins.lower_byte_mask;
  a_apb_ready_next: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held past one cycle");
  a_unmapped_err: assert property (apb_rsp.pready && apb_req.paddr > 12'h00C |-> apb_rsp.pslverr)
    else $error("unmapped access without pslverr");
  a_rd_drive_cl2: assert property (rd && !lat3_r && unmasked |-> ##2 dq_oe == 2'h3)
    else $error("drivers late at latency two");
  a_rd_drive_cl3: assert property (rd && lat3_r ##1 unmasked |-> ##2 dq_oe == 2'h3)
    else $error("drivers late at latency three");
  a_rd_release: assert property (rd && !lat3_r && bl_r == 3'h0 ##1 !rd |-> ##2 dq_oe == 2'h0)
    else $error("drivers not released after single word");
  a_upper_mask_gap: assert property (dq_oe[1] |-> !$past(sd_pins.upper_byte_mask, 2))
    else $error("upper byte driven two cycles after mask");
  a_lower_mask_gap: assert property (dq_oe[0] |-> !$past(sd_pins.lower_byte_mask, 2))
    else $error("lower byte driven two cycles after mask");
  a_reset_quiet: assert property ($rose(presetn) |-> dq_oe == 2'h0 && !apb_rsp.pready)
    else $error("outputs active at reset release");
  c_cl3_read: cover property (rd && lat3_r);
  c_slverr: cover property (apb_rsp.pslverr);
  c_half_mask: cover property (dq_oe == 2'h2);
endmodule
`default_nettype wire

// ===== bench/sdram_ctrl_model.sv
// memory controller model driving the command pins and write data
`default_nettype none
module sdram_ctrl_model (
  input wire logic clk,
  output sdram_core_pkg::sdram_pins_s pins,
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // deselected pins and a quiet bus at time zero
  initial
  begin
    pins = '1;
    dq = 16'h0000;
  end
  // one command per edge; an undriven bus flips so no stale word looks valid
  task automatic step(input logic [3:0] c, input logic [11:0] a, input logic [1:0] m, input logic den,
                      input logic [15:0] d);
    @(posedge clk);
    pins <= {c, a, m};
    dq <= den ? d : ~dq;
  endtask
endmodule
`default_nettype wire

// ===== bench/sdram_burst_bank_command_core_tb_top.sv
// self-checking bench: apb rows first, then burst and bank scenarios
`default_nettype none
module sdram_burst_bank_command_core_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [3:0] NOP = 4'hF;
  localparam logic [3:0] ACT = 4'h3;
  localparam logic [3:0] RD = 4'h5;
  localparam logic [3:0] WR = 4'h4;
  localparam logic [3:0] PRE = 4'h2;
  localparam logic [3:0] BST = 4'h6;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] d;
    logic err;
    logic [31:0] q;
  } row_s;
  logic pclk;
  logic presetn;
  sdram_core_pkg::apb_req_s apb_req;
  sdram_core_pkg::apb_rsp_s apb_rsp;
  sdram_core_pkg::sdram_pins_s sd_pins;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  logic [1:0] dq_oe;
  int failures;
  int n_tests;
  logic [31:0] q;
  logic e;
  logic [15:0] ev [0:3];
  logic [31:0] x3 [0:6];
  row_s rows [0:7];
  sdram_burst_bank_command_core dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .sd_pins(sd_pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  sdram_ctrl_model ctl (.clk(pclk), .pins(sd_pins), .dq(dq_in));
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      $display("mismatch %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask
  task automatic nop(input int n);
    repeat (n) ctl.step(NOP, 12'h000, 2'h0, 1'h0, 16'h0000);
  endtask
  // setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    @(posedge pclk);
    apb_req <= {1'h1, 1'h0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'h1;
    n = 0;
    // look between edges: pready seen high here is what the next edge samples
    #1;
    while (apb_rsp.pready !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    rdy = apb_rsp.pready;
    // the access edge itself; release only after it
    @(posedge pclk);
    apb_req <= '0;
    chk("pready", 32'h1, {31'h0, rdy});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] care, input logic [31:0] ex);
    apb(1'h0, a, 32'h0);
    chk("reg", ex, q & care);
  endtask
  // latency two read; full page expects the column number, short bursts the ev table
  task automatic rdb(input logic [11:0] a, input int n);
    ctl.step(RD, a, 2'h0, 1'h0, 16'h0000);
    nop(1);
    for (int k = 0; k < n; k++)
    begin
      nop(1);
      #1;
      chk("rd", {14'h0, 2'h3, n > 4 ? 16'(k % 256) : ev[k]}, {14'h0, dq_oe, dq_out});
    end
  endtask
  // 250 mhz clock
  initial
  begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // watchdog well beyond the expected run of about 650 cycles
  initial
  begin
    #40000;
    failures++;
    print_verdict();
  end
  initial
  begin
    presetn = 1'h0;
    apb_req = '0;
    failures = 0;
    n_tests = 0;
    rows = '{{1'h0, 12'h000, 32'h0, 1'h0, 32'h0}, {1'h0, 12'h004, 32'h0, 1'h0, 32'h0},
      {1'h0, 12'h008, 32'h0, 1'h0, 32'h0}, {1'h0, 12'h010, 32'h0, 1'h1, 32'h0},
      {1'h1, 12'h000, 32'h1F, 1'h0, 32'h0}, {1'h0, 12'h000, 32'h0, 1'h0, 32'h1F},
      {1'h1, 12'h00C, 32'hFFFFFFFF, 1'h0, 32'h0}, {1'h0, 12'h00C, 32'h0, 1'h0, 32'h0}};
    ev = '{16'h22F0, 16'h11F1, 16'h22F2, 16'h22F3};
    x3 = '{32'h22200, 32'h311F1, 32'h322F2, 32'h322F3, 32'h322F0, 32'h311F1, 32'h0};
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    chk("oe_reset", 32'h0, {30'h0, dq_oe});
    for (int i = 0; i < 8; i++)
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, e});
      if (!rows[i].wr)
        chk("prdata", rows[i].q, q);
    end
    ctl.step(ACT, 12'h005, 2'h0, 1'h0, 16'h0000);
    ctl.step(ACT, 12'h807, 2'h0, 1'h0, 16'h0000);
    nop(1);
    rchk(12'h00C, 32'hFFFFFFFF, 32'h00070005);
    // full page: write 256 words, read 258 with spare column bits and the auto-precharge bit set, which full page ignores
    apb(1'h1, 12'h000, 32'h0E);
    ctl.step(WR, 12'h000, 2'h0, 1'h1, 16'h0000);
    for (int i = 1; i < 256; i++)
      ctl.step(NOP, 12'h000, 2'h0, 1'h1, 16'(i));
    ctl.step(BST, 12'h000, 2'h0, 1'h0, 16'h0000);
    nop(2);
    rdb(12'h700, 258);
    ctl.step(BST, 12'h000, 2'h0, 1'h0, 16'h0000);
    nop(2);
    #1;
    chk("bst_release", 32'h0, {30'h0, dq_oe});
    rchk(12'h004, 32'h3, 32'h3);
    // burst of four, second write cuts in, upper byte of its second word masked
    apb(1'h1, 12'h000, 32'h04);
    for (int i = 0; i < 6; i++)
      ctl.step(i == 0 || i == 2 ? WR : NOP, 12'h008, {i == 3, 1'h0}, 1'h1, 16'h22EE + 16'(i) - (i < 2 ? 16'h11EE : 16'h0));
    nop(1);
    rdb(12'h008, 4);
    // latency three: lower mask for one edge, then a replacing read
    apb(1'h1, 12'h000, 32'h05);
    ctl.step(RD, 12'h008, 2'h0, 1'h0, 16'h0000);
    ctl.step(NOP, 12'h000, 2'h1, 1'h0, 16'h0000);
    ctl.step(RD, 12'h00A, 2'h0, 1'h0, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      nop(1);
      #1;
      chk("cl3", x3[i], {14'h0, dq_oe, dq_out} & (i == 0 ? 32'h3FF00 : i == 6 ? 32'h30000 : 32'h3FFFF));
    end
    // precharge two edges into a burst of eight
    apb(1'h1, 12'h000, 32'h06);
    ctl.step(RD, 12'h000, 2'h0, 1'h0, 16'h0000);
    nop(1);
    ctl.step(PRE, 12'h000, 2'h0, 1'h0, 16'h0000);
    nop(1);
    #1;
    chk("trunc", 32'h30001, {14'h0, dq_oe, dq_out});
    nop(1);
    #1;
    chk("trunc_end", 32'h0, {30'h0, dq_oe});
    rchk(12'h004, 32'h3, 32'h2);
    rchk(12'h008, 32'h7, 32'h0);
    // read to the closed bank is flagged, flag cleared by writing one
    apb(1'h1, 12'h000, 32'h00);
    ctl.step(RD, 12'h000, 2'h0, 1'h0, 16'h0000);
    nop(2);
    rchk(12'h008, 32'h7, 32'h2);
    apb(1'h1, 12'h008, 32'h2);
    rchk(12'h008, 32'h7, 32'h0);
    ctl.step(PRE, 12'h400, 2'h0, 1'h0, 16'h0000);
    nop(1);
    rchk(12'h004, 32'h3, 32'h0);
    nop(5);
    ctl.step(ACT, 12'h807, 2'h0, 1'h0, 16'h0000);
    nop(11);
    ctl.step(WR, 12'hC03, 2'h0, 1'h1, 16'h5A5A);
    nop(1);
    rchk(12'h004, 32'hA, 32'h8);
    rchk(12'h008, 32'h7, 32'h0);
    print_verdict();
  end
endmodule
bind sdram_burst_bank_command_core sdram_core_checker chk_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .sd_pins(sd_pins), .dq_out(dq_out), .dq_oe(dq_oe));
`default_nettype wire
